// File: core/fcs_sequencer.sv
// Contract
// - divider register takes one write only
// - byte program 9 cycles, burst byte 4
// - page erase 4000, mass erase 20000 cycles
// - array write latches command address and data
// - page erase selects page; data ignored otherwise
// - decode 05 blank, 20 byte, 25 burst
// - decode 40 page, 41 mass; others invalid
// - writing one to buffer empty launches command
// - writing zero before launch aborts, sets error
// - command complete flag shows finished execution
// - burst keeps pump on for queued same-row byte
// - first and new-row burst bytes take standard time
// - no queued burst byte turns pump off
// - access error blocks commands; write one clears
// - array write early or buffer full errors
// - second array or command write errors
// - out-of-order control register writes error; a command write with no array write before it is ignored
// - invalid command code sets access error
// - stop mode aborts running command with error
// - secured debug path allows only check, mass
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/10ps
module fcs_sequencer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [17:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // chip status
  input  wire logic        dbg_access_i,
  input  wire logic        stop_req_i,
  input  wire logic        secured_i,
  // flash array control
  output logic      [15:0] fl_addr_o,
  output logic      [7:0]  fl_data_o,
  output logic             fl_pump_o,
  output logic             fl_prog_o,
  output logic             fl_erase_o,
  output logic             fl_mass_o,
  output logic             fl_blank_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                      ack;
    logic [31:0]               rdata;
    logic [fcs_pkg::DIV_W-1:0] div;
    logic                      div_set;
    logic                      cbef;
    logic                      ccf;
    logic                      accerr;
    fcs_pkg::fcs_phase_t       phase;
    logic [15:0]               buf_addr;
    logic [7:0]                buf_data;
    logic [7:0]                buf_cmd;
    fcs_pkg::fcs_exec_t        ex;
    logic [15:0]               cur_addr;
    logic [7:0]                cur_data;
    logic [7:0]                cur_cmd;
    logic [fcs_pkg::CNT_W-1:0] cnt;
    logic                      pump;
  } fcs_seq_t;

  fcs_seq_t s_ff;
  fcs_seq_t nxt_s;

  logic       tick;
  logic [1:0] sync_lv;
  logic       stop_req;
  logic       secured;
  logic       req;
  logic       wr;
  logic       is_arr;
  logic       hit_div;
  logic       hit_stat;
  logic       hit_cmd;
  logic       err;
  logic       go_launch;
  logic       go_abort;
  logic       bad_cmd;
  logic       ex_start;
  logic       ex_done;
  logic       keep_burst;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic cmd_valid(input logic [7:0] c);
    cmd_valid = (c == fcs_pkg::CMD_BLANK) || (c == fcs_pkg::CMD_BYTE) ||
                (c == fcs_pkg::CMD_BURST) || (c == fcs_pkg::CMD_PAGE) ||
                (c == fcs_pkg::CMD_MASS);
  endfunction

  function automatic logic [14:0] cmd_cycles(input logic [7:0] c);
    case (c)
      fcs_pkg::CMD_PAGE:  cmd_cycles = fcs_pkg::CYC_PAGE;
      fcs_pkg::CMD_MASS:  cmd_cycles = fcs_pkg::CYC_MASS;
      fcs_pkg::CMD_BLANK: cmd_cycles = fcs_pkg::CYC_BLANK;
      default:            cmd_cycles = fcs_pkg::CYC_BYTE;
    endcase
  endfunction

  // stop and security come from other clock domains
  fcs_sync #(
    .W (2)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i ({stop_req_i, secured_i}),
    .sync_o  (sync_lv)
  );

  assign stop_req = sync_lv[1];
  assign secured  = sync_lv[0];

  fcs_divided_flash_clock_div u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .en_i   (s_ff.div_set),
    .div_i  (s_ff.div),
    .tick_o (tick)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_s      = s_ff;
    err        = 1'b0;
    go_launch  = 1'b0;
    go_abort   = 1'b0;
    bad_cmd    = 1'b0;
    ex_start   = 1'b0;
    ex_done    = 1'b0;
    keep_burst = 1'b0;
    // one-cycle ack, so every request is answered, mapped or not
    nxt_s.ack  = wb_cyc_i & wb_stb_i & ~s_ff.ack;
    req        = nxt_s.ack;
    wr         = req & wb_we_i & wb_sel_i[0];
    is_arr     = wb_adr_i[fcs_pkg::ARRAY_BIT];
    hit_div    = ~is_arr & (wb_adr_i == fcs_pkg::REG_DIV_ADR);
    hit_stat   = ~is_arr & (wb_adr_i == fcs_pkg::REG_STAT_ADR);
    hit_cmd    = ~is_arr & (wb_adr_i == fcs_pkg::REG_CMD_ADR);

    // register reads
    if (req & ~wb_we_i)
    begin
      nxt_s.rdata = '0;
      if (hit_div)
      begin
        nxt_s.rdata[fcs_pkg::DIV_W-1:0]    = s_ff.div;
        nxt_s.rdata[fcs_pkg::DIV_SET_BIT]  = s_ff.div_set;
      end
      else if (hit_stat)
      begin
        nxt_s.rdata[fcs_pkg::ST_CBEF_BIT]   = s_ff.cbef;
        nxt_s.rdata[fcs_pkg::ST_CCF_BIT]    = s_ff.ccf;
        nxt_s.rdata[fcs_pkg::ST_ACCERR_BIT] = s_ff.accerr;
      end
      else if (hit_cmd)
        nxt_s.rdata[7:0] = s_ff.buf_cmd;
    end

    // execution engine
    case (s_ff.ex)
      fcs_pkg::EX_IDLE:
      begin
        if (~s_ff.cbef & ~stop_req)
        begin
          ex_start       = 1'b1;
          nxt_s.ex       = fcs_pkg::EX_RUN;
          nxt_s.cbef     = 1'b1;
          nxt_s.cur_cmd  = s_ff.buf_cmd;
          nxt_s.cnt      = cmd_cycles(s_ff.buf_cmd);
          nxt_s.pump     = (s_ff.buf_cmd != fcs_pkg::CMD_BLANK);
          // erase works on whole pages, data only matters when programming
          nxt_s.cur_addr = (s_ff.buf_cmd == fcs_pkg::CMD_PAGE) ?
                           (s_ff.buf_addr & fcs_pkg::PAGE_MASK) : s_ff.buf_addr;
          nxt_s.cur_data = ((s_ff.buf_cmd == fcs_pkg::CMD_BYTE) ||
                            (s_ff.buf_cmd == fcs_pkg::CMD_BURST)) ? s_ff.buf_data : '0;
        end
      end
      fcs_pkg::EX_RUN:
      begin
        if (stop_req)
        begin
          // queued work is dropped too, the array state is unknown
          nxt_s.ex   = fcs_pkg::EX_IDLE;
          nxt_s.pump = 1'b0;
          nxt_s.cbef = 1'b1;
          err        = 1'b1;
        end
        else if (tick)
        begin
          if (s_ff.cnt == fcs_pkg::CYC_LAST)
          begin
            ex_done    = 1'b1;
            keep_burst = (s_ff.cur_cmd == fcs_pkg::CMD_BURST) & ~s_ff.cbef &
                         (s_ff.buf_cmd == fcs_pkg::CMD_BURST) &
                         (s_ff.buf_addr[15:fcs_pkg::ROW_LSB] ==
                          s_ff.cur_addr[15:fcs_pkg::ROW_LSB]) &
                         (s_ff.buf_addr[fcs_pkg::ROW_LSB-1:0] != fcs_pkg::ROW_START);
            if (keep_burst)
            begin
              nxt_s.cbef     = 1'b1;
              nxt_s.cur_addr = s_ff.buf_addr;
              nxt_s.cur_data = s_ff.buf_data;
              nxt_s.cnt      = fcs_pkg::CYC_BURST;
            end
            else
            begin
              // a new row or a late byte restarts at standard time
              nxt_s.ex   = fcs_pkg::EX_IDLE;
              nxt_s.pump = 1'b0;
            end
          end
          else
            nxt_s.cnt = s_ff.cnt - fcs_pkg::CYC_LAST;
        end
      end
      default:
      begin
        nxt_s.ex   = fcs_pkg::EX_IDLE;
        nxt_s.pump = 1'b0;
      end
    endcase

    // array write, first step of every command
    if (wr & is_arr & ~s_ff.accerr)
    begin
      if (~s_ff.div_set | ~s_ff.cbef)
        err = 1'b1;
      else if (s_ff.phase != fcs_pkg::PH_IDLE)
        err = 1'b1;
      else
      begin
        nxt_s.buf_addr = wb_adr_i[15:0];
        nxt_s.buf_data = wb_dat_i[7:0];
        nxt_s.phase    = fcs_pkg::PH_ADDR;
      end
    end

    // divider: one write after reset, later ones dropped
    if (wr & hit_div)
    begin
      if (s_ff.phase != fcs_pkg::PH_IDLE)
        err = 1'b1;
      else if (~s_ff.div_set)
      begin
        nxt_s.div     = wb_dat_i[fcs_pkg::DIV_W-1:0];
        nxt_s.div_set = 1'b1;
      end
    end

    // command code
    if (wr & hit_cmd & ~s_ff.accerr)
    begin
      if (s_ff.phase == fcs_pkg::PH_CMD)
        err = 1'b1;
      else if (s_ff.phase == fcs_pkg::PH_ADDR)
      begin
        bad_cmd = ~cmd_valid(wb_dat_i[7:0]) |
                  (secured & dbg_access_i &
                   ((wb_dat_i[7:0] == fcs_pkg::CMD_BYTE) ||
                    (wb_dat_i[7:0] == fcs_pkg::CMD_BURST) ||
                    (wb_dat_i[7:0] == fcs_pkg::CMD_PAGE)));
        if (bad_cmd)
          err = 1'b1;
        else
        begin
          nxt_s.buf_cmd = wb_dat_i[7:0];
          nxt_s.phase   = fcs_pkg::PH_CMD;
        end
      end
    end

    // status: launch, abort, error clear
    if (wr & hit_stat)
    begin
      if (s_ff.phase == fcs_pkg::PH_CMD)
      begin
        if (wb_dat_i[fcs_pkg::ST_CBEF_BIT])
        begin
          go_launch   = 1'b1;
          nxt_s.cbef  = 1'b0;
          nxt_s.phase = fcs_pkg::PH_IDLE;
        end
        else
        begin
          go_abort = 1'b1;
          err      = 1'b1;
        end
      end
      else if (s_ff.phase == fcs_pkg::PH_ADDR)
      begin
        go_abort = ~wb_dat_i[fcs_pkg::ST_CBEF_BIT];
        err      = 1'b1;
      end
    end

    // any error cancels the partial command
    if (err)
      nxt_s.phase = fcs_pkg::PH_IDLE;

    // a new error wins over a clear in the same cycle
    nxt_s.accerr = (s_ff.accerr &
                    ~(wr & hit_stat & wb_dat_i[fcs_pkg::ST_ACCERR_BIT])) | err;
    nxt_s.ccf    = (nxt_s.ex == fcs_pkg::EX_IDLE) & nxt_s.cbef;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_ff      <= '0;
      s_ff.cbef <= 1'b1;
      s_ff.ccf  <= 1'b1;
    end
    else if (ce_i)
      s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign wb_ack_o   = s_ff.ack;
  assign wb_dat_o   = s_ff.rdata;
  assign fl_addr_o  = s_ff.cur_addr;
  assign fl_data_o  = s_ff.cur_data;
  assign fl_pump_o  = s_ff.pump;
  assign fl_prog_o  = (s_ff.ex == fcs_pkg::EX_RUN) &
                      ((s_ff.cur_cmd == fcs_pkg::CMD_BYTE) |
                       (s_ff.cur_cmd == fcs_pkg::CMD_BURST));
  assign fl_erase_o = (s_ff.ex == fcs_pkg::EX_RUN) & (s_ff.cur_cmd == fcs_pkg::CMD_PAGE);
  assign fl_mass_o  = (s_ff.ex == fcs_pkg::EX_RUN) & (s_ff.cur_cmd == fcs_pkg::CMD_MASS);
  assign fl_blank_o = (s_ff.ex == fcs_pkg::EX_RUN) & (s_ff.cur_cmd == fcs_pkg::CMD_BLANK);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_launch_req;
    ce_i & go_launch;
  endsequence

  sequence s_cmd_taken;
    ~s_ff.cbef ##1 s_ff.cbef;
  endsequence

  property p_div_once;
    ce_i & wr & hit_div & s_ff.div_set |=> s_ff.div == $past(s_ff.div);
  endproperty
  a_div_once: assert property (p_div_once) else $error("divider rewritten");

  property p_launch;
    s_launch_req ##0 ((s_ff.ex == fcs_pkg::EX_IDLE) & ~stop_req) ##1 ce_i
      |-> s_ff.ccf == 1'b0;
  endproperty
  a_launch: assert property (p_launch) else $error("complete flag set after launch");

  property p_launch_cbef;
    s_launch_req ##0 (~stop_req & (s_ff.ex == fcs_pkg::EX_IDLE)) ##1 (ce_i & ~stop_req)
      |-> s_cmd_taken;
  endproperty
  a_launch_cbef: assert property (p_launch_cbef) else $error("buffer flag sequence wrong");

  property p_abort;
    ce_i & go_abort |=> s_ff.accerr & (s_ff.phase == fcs_pkg::PH_IDLE);
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not flag error");

  property p_bad_cmd;
    ce_i & bad_cmd |=> s_ff.accerr & (s_ff.phase != fcs_pkg::PH_CMD);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad code accepted");

  property p_stop;
    ce_i & stop_req & (s_ff.ex == fcs_pkg::EX_RUN)
      |=> (s_ff.ex == fcs_pkg::EX_IDLE) & s_ff.accerr & ~s_ff.pump;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not abort");

  property p_start_time;
    ce_i & ex_start |=> s_ff.cnt == $past(cmd_cycles(s_ff.buf_cmd));
  endproperty
  a_start_time: assert property (p_start_time) else $error("wrong start count");

  property p_page_time;
    ce_i & ex_start & (s_ff.buf_cmd == fcs_pkg::CMD_PAGE) |=> s_ff.cnt == fcs_pkg::CYC_PAGE;
  endproperty
  a_page_time: assert property (p_page_time) else $error("page erase time wrong");

  property p_burst_keep;
    ce_i & keep_burst
      |=> s_ff.pump & (s_ff.cnt == fcs_pkg::CYC_BURST) & (s_ff.ex == fcs_pkg::EX_RUN);
  endproperty
  a_burst_keep: assert property (p_burst_keep) else $error("burst pump dropped");

  property p_pump_off;
    ce_i & ex_done & ~keep_burst |=> ~s_ff.pump ##1 (~s_ff.pump | ~ce_i | $past(ex_start));
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump left on");

  property p_err_block;
    s_ff.accerr & ce_i & wr & is_arr |=> s_ff.phase == $past(s_ff.phase);
  endproperty
  a_err_block: assert property (p_err_block) else $error("array write taken in error");

endmodule

// File: core/fcs_pkg.sv
package fcs_pkg;

  // ----------------------------------------------------------------------
  // bus map
  // ----------------------------------------------------------------------
  localparam int          ADR_W         = 18;
  localparam int          ARRAY_BIT     = 17;
  localparam logic [17:0] REG_DIV_ADR   = 18'h00000;
  localparam logic [17:0] REG_STAT_ADR  = 18'h00004;
  localparam logic [17:0] REG_CMD_ADR   = 18'h00008;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int          DIV_W         = 7;
  localparam int          DIV_SET_BIT   = 7;
  localparam int          ST_CBEF_BIT   = 7;
  localparam int          ST_CCF_BIT    = 6;
  localparam int          ST_ACCERR_BIT = 4;
  localparam int          ROW_LSB       = 6;
  localparam logic [15:0] PAGE_MASK     = 16'hfe00;
  localparam logic [5:0]  ROW_START     = 6'h00;

  // ----------------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CMD_BLANK     = 8'h05;
  localparam logic [7:0]  CMD_BYTE      = 8'h20;
  localparam logic [7:0]  CMD_BURST     = 8'h25;
  localparam logic [7:0]  CMD_PAGE      = 8'h40;
  localparam logic [7:0]  CMD_MASS      = 8'h41;

  // ----------------------------------------------------------------------
  // timing in divided flash clock cycles
  // ----------------------------------------------------------------------
  localparam int          CNT_W         = 15;
  localparam logic [14:0] CYC_BYTE      = 15'h0009;
  localparam logic [14:0] CYC_BURST     = 15'h0004;
  localparam logic [14:0] CYC_PAGE      = 15'h0fa0;
  localparam logic [14:0] CYC_MASS      = 15'h4e20;
  localparam logic [14:0] CYC_BLANK     = 15'h0009;
  localparam logic [14:0] CYC_LAST      = 15'h0001;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          DIVIDED_FLASH_CLOCK_MIN_HZ   = 150_000;
  localparam int          DIVIDED_FLASH_CLOCK_MAX_HZ   = 200_000;
  localparam int          DIV_LO        = CLK_HZ / DIVIDED_FLASH_CLOCK_MAX_HZ - 1;
  localparam int          DIV_HI        = CLK_HZ / DIVIDED_FLASH_CLOCK_MIN_HZ - 1;

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_CMD  = 2'b10
  } fcs_phase_t;

  typedef enum logic [0:0] {
    EX_IDLE = 1'b0,
    EX_RUN  = 1'b1
  } fcs_exec_t;

endpackage

// File: core/fcs_sync.sv
`timescale 1ns/10ps
module fcs_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } fcs_sync_t;

  fcs_sync_t s_ff;
  fcs_sync_t nxt_s;

  // first stage feeds only the second stage
  always_comb
  begin
    nxt_s      = s_ff;
    nxt_s.meta = async_i;
    nxt_s.q    = s_ff.meta;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_ff <= '0;
    else if (ce_i)
      s_ff <= nxt_s;
  end

  assign sync_o = s_ff.q;

endmodule

// File: core/fcs_divided_flash_clock_div.sv
`timescale 1ns/10ps
module fcs_divided_flash_clock_div (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // setting
  input  wire logic                     en_i,
  input  wire logic [fcs_pkg::DIV_W-1:0] div_i,
  // divided flash clock, one bus cycle per period
  output logic                          tick_o
);

  typedef struct packed {
    logic [fcs_pkg::DIV_W-1:0] cnt;
    logic                      tick;
  } fcs_div_t;

  fcs_div_t s_ff;
  fcs_div_t nxt_s;

  // period is div_i + 1 bus cycles
  always_comb
  begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (!en_i)
      nxt_s.cnt = '0;
    else if (s_ff.cnt == div_i)
    begin
      nxt_s.cnt  = '0;
      nxt_s.tick = 1'b1;
    end
    else
      nxt_s.cnt = s_ff.cnt + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_ff <= '0;
    else if (ce_i)
      s_ff <= nxt_s;
  end

  assign tick_o = s_ff.tick;

endmodule

// File: tb/fcs_wb_master.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// bus master model: classic single cycles, one at a time
// ----------------------------------------------------------------------
module fcs_wb_master (
  // clock
  input  wire logic        clk_i,
  // wishbone master
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic      [17:0] wb_adr_o,
  output logic      [3:0]  wb_sel_o,
  output logic      [31:0] wb_dat_o,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_i
);
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 18'h00000;
    wb_sel_o = 4'h1;
    wb_dat_o = 32'h00000000;
  end

  // request held until ack is sampled; data lines scrambled once released
  task automatic xfer(input logic we, input logic [17:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_sel_o <= 4'h1;
    wb_adr_o <= a;
    wb_dat_o <= {24'h000000, d};
    do
      @(posedge clk_i);
    while (wb_ack_i !== 1'b1);
    q = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_dat_o <= ~wb_dat_o;
    @(posedge clk_i);
  endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // ----------------------------------------------------------------------
  // clock, reset, wiring
  // ----------------------------------------------------------------------
  localparam logic [17:0] AR = 18'h21000;
  localparam logic [17:0] ST = fcs_pkg::REG_STAT_ADR;
  localparam logic [17:0] CM = fcs_pkg::REG_CMD_ADR;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        stop  = 1'b0;
  logic        sec   = 1'b0;
  logic        dbg   = 1'b0;
  logic        cyc, stb, we, ack, pump, prog, ers, mass, blank;
  logic [17:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [15:0] faddr;
  logic [7:0]  fdata, st;
  logic [4:0]  fl;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #50 clk_i = ~clk_i;
  assign fl = {blank, mass, ers, prog, pump};

  fcs_wb_master u_fcs_wb_master (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
    .wb_dat_i(rdat), .wb_ack_i(ack));

  fcs_sequencer u_fcs_sequencer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dbg_access_i(dbg),
    .stop_req_i(stop), .secured_i(sec), .fl_addr_o(faddr), .fl_data_o(fdata),
    .fl_pump_o(pump), .fl_prog_o(prog), .fl_erase_o(ers), .fl_mass_o(mass),
    .fl_blank_o(blank));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // cycle ceiling: mass erase alone is some 40000 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      errors++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi)
    begin
      errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_fcs_wb_master.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [17:0] a);
    u_fcs_wb_master.xfer(1'b0, a, 8'h00, st);
  endtask

  task automatic seq(input logic [15:0] fa, input logic [7:0] d, input logic [7:0] c);
    wr({2'b10, fa}, d);
    wr(CM, c);
    wr(ST, 8'h80);
  endtask

  task automatic wait_idle();
    st = 8'h00;
    while (st[6] !== 1'b1)
      rd(ST);
  endtask

  // bench-side count of cycles one flash control line stays high
  task automatic hi_len(input int k, output int n);
    n = 0;
    while (fl[k] !== 1'b1)
      @(posedge clk_i);
    while (fl[k] === 1'b1)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_div();
    chk("fl", 16'h0000, 16'(fl));
    rd(ST);
    chk("st rst", 16'h00c0, 16'(st));
    wr(AR, 8'h01);
    rd(ST);
    chk("err early", 16'h0010, 16'(st & 8'h10));
    wr(ST, 8'h10);
    wr(fcs_pkg::REG_DIV_ADR, 8'h01);
    wr(fcs_pkg::REG_DIV_ADR, 8'h05);
    rd(fcs_pkg::REG_DIV_ADR);
    chk("div", 16'h0081, 16'(st));
    $display("test div done");
  endtask

  task automatic t_cmd(input logic [7:0] c, input int k, input int t);
    int n;
    logic is_pg;
    logic is_pr;
    is_pg = (c == fcs_pkg::CMD_PAGE);
    is_pr = (c == fcs_pkg::CMD_BYTE) || (c == fcs_pkg::CMD_BURST);
    fork
      begin
        seq(16'h1234, 8'h5a, c);
        chk("addr", is_pg ? 16'h1200 : 16'h1234, faddr);
        chk("data", is_pr ? 16'h005a : 16'h0000, 16'(fdata));
        chk("pump", 16'(c != fcs_pkg::CMD_BLANK), 16'(pump));
        rd(ST);
        chk("st run", 16'h0080, 16'(st & 8'hc0));
      end
      hi_len(k, n);
    join
    chk_rng("len", 2 * t - 2, 2 * t + 1, n);
    wait_idle();
    chk("st end", 16'h00c0, 16'(st));
    $display("test cmd %h done", c);
  endtask

  task automatic t_burst(input logic [15:0] a2, input int t);
    int n;
    fork
      begin
        seq(a2 - 16'h0001, 8'h11, fcs_pkg::CMD_BURST);
        seq(a2, 8'h22, fcs_pkg::CMD_BURST);
      end
      hi_len(0, n);
    join
    chk_rng("pump len", 2 * t - 2, 2 * t + 1, n);
    wait_idle();
    chk("pump off", 16'h0000, 16'(pump));
    $display("test burst %h done", a2);
  endtask

  task automatic t_err(input int m, input logic [17:0] a, input logic [7:0] d);
    wr(AR, 8'h3c);
    if (m > 0)
      wr(CM, fcs_pkg::CMD_BYTE);
    wr(a, d);
    rd(ST);
    chk("err", 16'h0010, 16'(st & 8'h10));
    seq(16'h2000, 8'h00, fcs_pkg::CMD_BYTE);
    chk("blocked", 16'h0000, 16'(prog));
    wr(ST, 8'h10);
    rd(ST);
    chk("cleared", 16'h00c0, 16'(st));
    $display("test err %h %h done", a, d);
  endtask

  task automatic t_stop();
    seq(16'h4000, 8'h00, fcs_pkg::CMD_PAGE);
    stop <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("abort", 16'h0000, 16'({ers, pump}));
    rd(ST);
    chk("stop err", 16'h0010, 16'(st & 8'h10));
    stop <= 1'b0;
    wr(ST, 8'h10);
    $display("test stop done");
  endtask

  task automatic t_secure();
    logic [7:0] bad [3];
    bad = '{fcs_pkg::CMD_BYTE, fcs_pkg::CMD_BURST, fcs_pkg::CMD_PAGE};
    sec <= 1'b1;
    dbg <= 1'b1;
    repeat (4) @(posedge clk_i);
    foreach (bad[i])
    begin
      wr(AR, 8'h00);
      wr(CM, bad[i]);
      rd(ST);
      chk("sec err", 16'h0010, 16'(st & 8'h10));
      wr(ST, 8'h10);
    end
    t_cmd(fcs_pkg::CMD_BLANK, 4, 9);
    sec <= 1'b0;
    dbg <= 1'b0;
    $display("test secure done");
  endtask

  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_div();
    t_cmd(fcs_pkg::CMD_BLANK, 4, 9);
    t_cmd(fcs_pkg::CMD_BYTE, 1, 9);
    t_cmd(fcs_pkg::CMD_BURST, 1, 9);
    t_cmd(fcs_pkg::CMD_PAGE, 2, 4000);
    t_cmd(fcs_pkg::CMD_MASS, 3, 20000);
    t_burst(16'h103f, 13);
    t_burst(16'h1080, 9);
    t_err(0, AR, 8'h01);
    t_err(1, CM, 8'h20);
    t_err(0, fcs_pkg::REG_DIV_ADR, 8'h01);
    t_err(1, fcs_pkg::REG_DIV_ADR, 8'h01);
    t_err(0, ST, 8'h00);
    t_err(1, ST, 8'h00);
    t_err(0, CM, 8'h33);
    t_stop();
    t_secure();
    finish_test();
  end
endmodule
